// file: rtl/fbs_pkg.sv
// Constants, types and state codes of the flow-through burst memory block.
// Assumes the controller outside runs on the same clock as this block.
`default_nettype none
package fbs_pkg;

    localparam int ADDR_W_DEF  = 20;
    localparam int LANES       = 4;
    localparam int LANE_W      = 8;
    localparam int DATA_W      = LANES * LANE_W;
    localparam int BURST_W     = 2;
    localparam int WBUF_DEPTH  = 16;

    localparam logic [BURST_W-1:0] BURST_START = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;

    // The order pin is pulled high, so interleaved order is the idle assumption.
    localparam logic ORDER_INTERLEAVED = 1'h1;
    localparam logic ORDER_RESET       = ORDER_INTERLEAVED;

    localparam logic [LANES-1:0] LANES_NONE = 4'h0;

    typedef enum logic [1:0] {
        FBS_ST_DESELECT = 2'h0,
        FBS_ST_READ     = 2'h1,
        FBS_ST_WRITE    = 2'h2
    } fbs_state_t;

endpackage
`default_nettype wire

// file: rtl/fbs_wbuf.sv
// Write buffer: a FIFO of address, lane mask and data words with a newest-wins lookup.
// Assumes one clock; the drain side may stall at any cycle.
`timescale 1ns/10ps
`default_nettype none
module fbs_wbuf #(
    parameter int DATA_W = 32,
    parameter int LANES  = 4,
    parameter int KEY_W  = 20,
    parameter int DEPTH  = 16
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // Filling side
    input  wire logic              in_valid_i,
    output logic                   in_ready_o,
    input  wire logic [KEY_W-1:0]  in_key_i,
    input  wire logic [LANES-1:0]  in_mask_i,
    input  wire logic [DATA_W-1:0] in_data_i,
    // Draining side
    output logic                   out_valid_o,
    input  wire logic              out_ready_i,
    output logic [KEY_W-1:0]       out_key_o,
    output logic [LANES-1:0]       out_mask_o,
    output logic [DATA_W-1:0]      out_data_o,
    // Lookup of pending lanes for one address
    input  wire logic [KEY_W-1:0]  look_key_i,
    output logic [LANES-1:0]       look_hit_o,
    output logic [DATA_W-1:0]      look_data_o
);
    localparam int PTR_W  = $clog2(DEPTH);
    localparam int CNT_W  = PTR_W + 1;
    localparam int LANE_W = DATA_W / LANES;

    initial
    begin
        if (DEPTH < 2 || (1 << PTR_W) != DEPTH || DATA_W % LANES != 0)
            $error("fbs_wbuf: depth must be a power of two and lanes must divide width");
    end

    logic [KEY_W-1:0]  key_mem  [DEPTH];
    logic [LANES-1:0]  mask_mem [DEPTH];
    logic [DATA_W-1:0] data_mem [DEPTH];
    logic [PTR_W-1:0]  wr_ptr_reg;
    logic [PTR_W-1:0]  rd_ptr_reg;
    logic [CNT_W-1:0]  count_reg;
    logic              push;
    logic              pop;
    logic [PTR_W-1:0]  idx;

    assign in_ready_o  = (count_reg != CNT_W'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_key_o   = key_mem[rd_ptr_reg];
    assign out_mask_o  = mask_mem[rd_ptr_reg];
    assign out_data_o  = data_mem[rd_ptr_reg];

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            key_mem[wr_ptr_reg]  <= in_key_i;
            mask_mem[wr_ptr_reg] <= in_mask_i;
            data_mem[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
            if (push && !pop)
                count_reg <= count_reg + CNT_W'(1);
            else if (pop && !push)
                count_reg <= count_reg - CNT_W'(1);
        end
    end

    // Walk oldest to newest so that a later write to a lane overrides an earlier one.
    always_comb
    begin
        look_hit_o  = '0;
        look_data_o = '0;
        idx         = '0;
        for (int i = 0; i < DEPTH; i++)
        begin
            idx = rd_ptr_reg + PTR_W'(i);
            if (CNT_W'(i) < count_reg && key_mem[idx] == look_key_i)
            begin
                for (int l = 0; l < LANES; l++)
                begin
                    if (mask_mem[idx][l])
                    begin
                        look_hit_o[l]                   = 1'b1;
                        look_data_o[l*LANE_W +: LANE_W] = data_mem[idx][l*LANE_W +: LANE_W];
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire

// file: rtl/fbs_ctrl.sv
// Flow-through burst memory: command decode, burst counter, storage and data drivers.
// Assumes the controls, address and write data are synchronous to SYS_CLK_I, while
// output enable is asynchronous and the order select pin is static.
`timescale 1ns/10ps
`default_nettype none
module fbs_ctrl #(
    parameter int ADDR_W     = fbs_pkg::ADDR_W_DEF,
    parameter int WBUF_DEPTH = fbs_pkg::WBUF_DEPTH
) (
    // Clock and reset
    input  wire logic                        SYS_CLK_I,
    input  wire logic                        NRST_I,
    // Chip enables
    input  wire logic                        CHIP_SELECT_FIRST_N_I,
    input  wire logic                        CHIP_SELECT_SECOND_I,
    input  wire logic                        CHIP_SELECT_THIRD_N_I,
    // Command controls
    input  wire logic                        ADVANCE_OR_LOAD_I,
    input  wire logic                        READ_NOT_WRITE_I,
    input  wire logic                        CLOCK_HOLD_N_I,
    // Byte lane write enables, active low
    input  wire logic                        LANE_A_WRITE_N_I,
    input  wire logic                        LANE_B_WRITE_N_I,
    input  wire logic                        LANE_C_WRITE_N_I,
    input  wire logic                        LANE_D_WRITE_N_I,
    // Static and asynchronous pins
    input  wire logic                        BURST_ORDER_SELECT_I,
    input  wire logic                        OUTPUT_ENABLE_N_I,
    // Address and data
    input  wire logic [ADDR_W-1:0]           ADDR_I,
    input  wire logic [fbs_pkg::DATA_W-1:0]  DQ_I,
    output logic [fbs_pkg::DATA_W-1:0]       DQ_O,
    output logic                             DQ_OE_O,
    // Status
    output logic                             WBUF_READY_O,
    output logic [1:0]                       BURST_STATE_O,
    output logic [ADDR_W-1:0]                BURST_ADDR_O
);
    localparam int LANES   = fbs_pkg::LANES;
    localparam int LANE_W  = fbs_pkg::LANE_W;
    localparam int DATA_W  = fbs_pkg::DATA_W;
    localparam int BURST_W = fbs_pkg::BURST_W;
    localparam int WORDS   = 1 << ADDR_W;

    initial
    begin
        if (ADDR_W <= BURST_W || ADDR_W > 24)
            $error("fbs_ctrl: address width must lie between 3 and 24 bits");
        if (WBUF_DEPTH < 2)
            $error("fbs_ctrl: write buffer needs at least two entries");
    end

    // Low address bits of a burst beat from the loaded bits and the beat count.
    function automatic logic [BURST_W-1:0] burst_low(
        input logic [BURST_W-1:0] base,
        input logic [BURST_W-1:0] beat,
        input logic               order
    );
        logic [BURST_W-1:0] low;
        low = '0;
        if (order == fbs_pkg::ORDER_INTERLEAVED)
            low = base ^ beat;
        else
            low = base + beat;
        return low;
    endfunction

    // True when a load cycle finds the chip enables in their active pattern.
    function automatic logic selected(
        input logic first_n,
        input logic second,
        input logic third_n
    );
        return !first_n && second && !third_n;
    endfunction

    // Storage array, lane writes come only from the write buffer.
    logic [DATA_W-1:0]       mem [WORDS];

    // Pin synchroniser for the static order select.
    logic                    order_meta_reg;
    logic                    order_reg;

    // Burst state.
    fbs_pkg::fbs_state_t     state_reg;
    fbs_pkg::fbs_state_t     state_next;
    logic [ADDR_W-1:0]       base_reg;
    logic [ADDR_W-1:0]       base_next;
    logic [BURST_W-1:0]      beat_reg;
    logic [BURST_W-1:0]      beat_next;

    // Data driver state.
    logic [DATA_W-1:0]       dq_reg;
    logic                    drive_reg;
    logic                    drive_next;

    // Decoded cycle.
    logic                    hold;
    logic                    load;
    logic                    advance;
    logic [LANES-1:0]        lane_wr_n;
    logic [LANES-1:0]        lane_en;
    logic                    any_lane;
    logic                    read_beat;
    logic                    write_beat;
    logic [ADDR_W-1:0]       beat_addr;
    logic [BURST_W-1:0]      next_beat;

    // Read path.
    logic [DATA_W-1:0]       mem_word;
    logic [DATA_W-1:0]       read_word;

    // Write buffer ports.
    logic                    wb_in_valid;
    logic                    wb_in_ready;
    logic                    wb_out_valid;
    logic                    wb_out_ready;
    logic [ADDR_W-1:0]       wb_out_key;
    logic [LANES-1:0]        wb_out_mask;
    logic [DATA_W-1:0]       wb_out_data;
    logic [LANES-1:0]        wb_look_hit;
    logic [DATA_W-1:0]       wb_look_data;

    // The pin is high for a hold: it is the clock enable, active low.
    assign hold      = CLOCK_HOLD_N_I;
    assign load      = !hold && !ADVANCE_OR_LOAD_I;
    assign advance   = !hold && ADVANCE_OR_LOAD_I;
    assign lane_wr_n = {LANE_D_WRITE_N_I, LANE_C_WRITE_N_I, LANE_B_WRITE_N_I, LANE_A_WRITE_N_I};
    assign lane_en   = ~lane_wr_n;
    assign any_lane  = (lane_en != fbs_pkg::LANES_NONE);
    assign next_beat = beat_reg + fbs_pkg::BURST_STEP;

    // The order pin is static but asynchronous, so it is resampled before use.
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            order_meta_reg <= fbs_pkg::ORDER_RESET;
            order_reg      <= fbs_pkg::ORDER_RESET;
        end
        else
        begin
            order_meta_reg <= BURST_ORDER_SELECT_I;
            order_reg      <= order_meta_reg;
        end
    end

    // Next burst state and the address of this beat.
    always_comb
    begin
        state_next = state_reg;
        base_next  = base_reg;
        beat_next  = beat_reg;
        drive_next = drive_reg;
        read_beat  = 1'b0;
        write_beat = 1'b0;
        beat_addr  = base_reg;
        if (load)
        begin
            beat_addr = ADDR_I;
            base_next = ADDR_I;
            beat_next = fbs_pkg::BURST_START;
            if (!selected(CHIP_SELECT_FIRST_N_I, CHIP_SELECT_SECOND_I, CHIP_SELECT_THIRD_N_I))
            begin
                state_next = fbs_pkg::FBS_ST_DESELECT;
                base_next  = base_reg;
                drive_next = 1'b0;
            end
            else if (READ_NOT_WRITE_I)
            begin
                state_next = fbs_pkg::FBS_ST_READ;
                read_beat  = 1'b1;
                drive_next = 1'b1;
            end
            else
            begin
                state_next = fbs_pkg::FBS_ST_WRITE;
                write_beat = any_lane;
                drive_next = 1'b0;
            end
        end
        else if (advance)
        begin
            // Chip enables and read/write are not looked at here; the latched kind rules.
            case (state_reg)
                fbs_pkg::FBS_ST_READ:
                begin
                    beat_next  = next_beat;
                    beat_addr  = {base_reg[ADDR_W-1:BURST_W],
                                  burst_low(base_reg[BURST_W-1:0], next_beat, order_reg)};
                    read_beat  = 1'b1;
                    drive_next = 1'b1;
                end
                fbs_pkg::FBS_ST_WRITE:
                begin
                    beat_next  = next_beat;
                    beat_addr  = {base_reg[ADDR_W-1:BURST_W],
                                  burst_low(base_reg[BURST_W-1:0], next_beat, order_reg)};
                    write_beat = any_lane;
                    drive_next = 1'b0;
                end
                fbs_pkg::FBS_ST_DESELECT:
                begin
                    drive_next = 1'b0;
                end
                default:
                begin
                    state_next = fbs_pkg::FBS_ST_DESELECT;
                    drive_next = 1'b0;
                end
            endcase
        end
    end

    // Burst state only moves on cycles that are not held.
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            state_reg <= fbs_pkg::FBS_ST_DESELECT;
            base_reg  <= '0;
            beat_reg  <= fbs_pkg::BURST_START;
        end
        else if (!hold)
        begin
            state_reg <= state_next;
            base_reg  <= base_next;
            beat_reg  <= beat_next;
        end
    end

    // Read data merges the array word with lanes still waiting in the write buffer,
    // so a read right after a write sees the new bytes.
    assign mem_word = mem[beat_addr];

    always_comb
    begin
        read_word = mem_word;
        for (int l = 0; l < LANES; l++)
        begin
            if (wb_look_hit[l])
                read_word[l*LANE_W +: LANE_W] = wb_look_data[l*LANE_W +: LANE_W];
        end
    end

    // Data is registered at the sampling edge and is on the pins in the cycle that
    // follows it, which is the flow-through access of that edge.
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            dq_reg <= '0;
        else if (read_beat)
            dq_reg <= read_word;
    end

    // A hold keeps the driver as it was: on in a read, off in a write.
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            drive_reg <= 1'b0;
        else if (!hold)
            drive_reg <= drive_next;
    end

    // Output enable gates the driver without waiting for a clock edge.
    assign DQ_OE_O = drive_reg && !OUTPUT_ENABLE_N_I;
    assign DQ_O    = dq_reg;

    // Write beats are queued; a beat that finds the buffer full is dropped like an
    // abort, so the controller must watch WBUF_READY_O before a write beat.
    assign wb_in_valid = write_beat;

    // The array has one port: a read beat or a held cycle stalls the drain.
    assign wb_out_ready = !read_beat && !hold;

    always_ff @(posedge SYS_CLK_I)
    begin
        if (wb_out_valid && wb_out_ready)
        begin
            for (int l = 0; l < LANES; l++)
            begin
                if (wb_out_mask[l])
                    mem[wb_out_key][l*LANE_W +: LANE_W] <= wb_out_data[l*LANE_W +: LANE_W];
            end
        end
    end

    fbs_wbuf #(
        .DATA_W (DATA_W),
        .LANES  (LANES),
        .KEY_W  (ADDR_W),
        .DEPTH  (WBUF_DEPTH)
    ) u_wbuf (
        .clk_i       (SYS_CLK_I),
        .rst_n_i     (NRST_I),
        .in_valid_i  (wb_in_valid),
        .in_ready_o  (wb_in_ready),
        .in_key_i    (beat_addr),
        .in_mask_i   (lane_en),
        .in_data_i   (DQ_I),
        .out_valid_o (wb_out_valid),
        .out_ready_i (wb_out_ready),
        .out_key_o   (wb_out_key),
        .out_mask_o  (wb_out_mask),
        .out_data_o  (wb_out_data),
        .look_key_i  (beat_addr),
        .look_hit_o  (wb_look_hit),
        .look_data_o (wb_look_data)
    );

    assign WBUF_READY_O  = wb_in_ready;
    assign BURST_STATE_O = state_reg;
    assign BURST_ADDR_O  = {base_reg[ADDR_W-1:BURST_W],
                            burst_low(base_reg[BURST_W-1:0], beat_reg, order_reg)};

endmodule
`default_nettype wire

// file: rtl/fbs_dummy_unused_placeholder_never.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: verif/fbs_ctrl_properties.sv
// Checker of the command decode, burst counter and drive rules at the memory block's ports.
// Assumes one clock and the block's asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module fbs_ctrl_properties #(
    parameter int ADDR_W = 6
) (
    // Clock and reset
    input  wire logic              SYS_CLK_I,
    input  wire logic              NRST_I,
    // Controls
    input  wire logic              CHIP_SELECT_FIRST_N_I,
    input  wire logic              CHIP_SELECT_SECOND_I,
    input  wire logic              CHIP_SELECT_THIRD_N_I,
    input  wire logic              ADVANCE_OR_LOAD_I,
    input  wire logic              READ_NOT_WRITE_I,
    input  wire logic              CLOCK_HOLD_N_I,
    input  wire logic              OUTPUT_ENABLE_N_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    // Observed outputs
    input  wire logic              DQ_OE_O,
    input  wire logic [1:0]        BURST_STATE_O,
    input  wire logic [ADDR_W-1:0] BURST_ADDR_O
);
    logic sel;
    logic load;
    logic adv;
    assign sel  = !CHIP_SELECT_FIRST_N_I && CHIP_SELECT_SECOND_I && !CHIP_SELECT_THIRD_N_I;
    assign load = !CLOCK_HOLD_N_I && !ADVANCE_OR_LOAD_I;
    assign adv  = !CLOCK_HOLD_N_I && ADVANCE_OR_LOAD_I;
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!NRST_I);
    a_oe_gates_drive: assert property (OUTPUT_ENABLE_N_I |-> !DQ_OE_O)
        else $error("drive enable high while output enable inactive");
    a_read_start: assert property (load && sel && READ_NOT_WRITE_I
        |=> BURST_STATE_O == 2'h1 && BURST_ADDR_O == $past(ADDR_I))
        else $error("read load did not start a read burst at the given address");
    a_read_drive: assert property (load && sel && READ_NOT_WRITE_I
        |=> DQ_OE_O == !OUTPUT_ENABLE_N_I)
        else $error("read load drive enable wrong");
    a_write_start: assert property (load && sel && !READ_NOT_WRITE_I
        |=> BURST_STATE_O == 2'h2 && !DQ_OE_O && BURST_ADDR_O == $past(ADDR_I))
        else $error("write load did not start an undriven write burst");
    a_deselect_load: assert property (load && !sel |=> BURST_STATE_O == 2'h0 && !DQ_OE_O)
        else $error("deselecting load did not deselect");
    a_advance_kind: assert property (adv |=> BURST_STATE_O == $past(BURST_STATE_O))
        else $error("advance changed the burst kind");
    a_hold_freeze: assert property (CLOCK_HOLD_N_I
        |=> $stable(BURST_STATE_O) && $stable(BURST_ADDR_O))
        else $error("held cycle changed state or address");
    a_hold_drive: assert property (CLOCK_HOLD_N_I ##1 $stable(OUTPUT_ENABLE_N_I)
        |-> $stable(DQ_OE_O))
        else $error("held cycle changed the drive");
    a_burst_step: assert property (adv && BURST_STATE_O != 2'h0
        |=> BURST_ADDR_O != $past(BURST_ADDR_O)
        && (BURST_ADDR_O >> 2) == ($past(BURST_ADDR_O) >> 2))
        else $error("advance did not step the low address bits only");
    a_burst_wrap: assert property (load && sel ##1 adv [*4]
        |=> BURST_ADDR_O == $past(BURST_ADDR_O, 4))
        else $error("burst did not wrap to the loaded address");
endmodule
bind fbs_ctrl fbs_ctrl_properties #(.ADDR_W(ADDR_W)) fbs_ctrl_properties_inst (
    .SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I), .CHIP_SELECT_FIRST_N_I(CHIP_SELECT_FIRST_N_I),
    .CHIP_SELECT_SECOND_I(CHIP_SELECT_SECOND_I), .CHIP_SELECT_THIRD_N_I(CHIP_SELECT_THIRD_N_I),
    .ADVANCE_OR_LOAD_I(ADVANCE_OR_LOAD_I), .READ_NOT_WRITE_I(READ_NOT_WRITE_I),
    .CLOCK_HOLD_N_I(CLOCK_HOLD_N_I), .OUTPUT_ENABLE_N_I(OUTPUT_ENABLE_N_I), .ADDR_I(ADDR_I),
    .DQ_OE_O(DQ_OE_O), .BURST_STATE_O(BURST_STATE_O), .BURST_ADDR_O(BURST_ADDR_O)
);
`default_nettype wire

// file: verif/fbs_host_model.sv
// Controller model: turns one bench request a cycle into the memory's control and data pins.
// Assumes the bench changes the request just after each rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module fbs_host_model #(
    parameter int ADDR_W = 6
) (
    // Request from the bench
    input  wire logic [2:0]                 op_i,
    input  wire logic                       hold_i,
    input  wire logic [3:0]                 lanes_n_i,
    input  wire logic [ADDR_W-1:0]          addr_i,
    input  wire logic [fbs_pkg::DATA_W-1:0] data_i,
    // Pins toward the memory
    output logic                            first_n_o,
    output logic                            second_o,
    output logic                            third_n_o,
    output logic                            adv_o,
    output logic                            rnw_o,
    output logic                            hold_o,
    output logic [3:0]                      lanes_n_o,
    output logic [ADDR_W-1:0]               addr_o,
    output logic [fbs_pkg::DATA_W-1:0]      data_o
);
    // Codes: 0 read, 1 write, 2 advance, 3 to 5 deselect by each chip enable in turn.
    // Advances drive deselecting enables and read select on purpose, since the memory must ignore them.
    always_comb
    begin
        first_n_o = (op_i == 3'h3) || (op_i == 3'h2);
        second_o  = (op_i != 3'h5);
        third_n_o = (op_i == 3'h4) || (op_i == 3'h2);
        adv_o     = (op_i == 3'h2);
        rnw_o     = (op_i != 3'h1);
        hold_o    = hold_i;
        lanes_n_o = lanes_n_i;
        addr_o    = adv_o ? ~addr_i : addr_i;
        // Write data goes with its command; otherwise a changing pattern, never the last word.
        data_o    = (op_i == 3'h1 || adv_o) ? data_i : ~data_i;
    end
endmodule
`default_nettype wire

// file: verif/test_flowthrough_burst_sram_control.sv
// Testbench of the flow-through burst memory: a command table, then reset and linear order.
// Assumes the controller model maps each request to pins within the same cycle.
`timescale 1ns/10ps
`default_nettype none
module test_flowthrough_burst_sram_control;
    typedef struct packed {
        logic [2:0]  op;
        logic        hold;
        logic        oe_n;
        logic [3:0]  lanes_n;
        logic [5:0]  addr;
        logic [31:0] data;
        logic        chk_dq;
        logic        exp_oe;
        logic [1:0]  exp_st;
        logic [5:0]  exp_ba;
    } fbs_row_t;
    // Output enable of a row applies in the cycle its answer is on the lines.
    localparam fbs_row_t IDLE = '{3'h3,1'h1,1'h1,4'hf,6'h0,32'h0,1'h0,1'h0,2'h0,6'h0};
    localparam fbs_row_t ROWS [0:24] = '{
        '{3'h1,1'h0,1'h0,4'h0,6'h11,32'h11111111,1'h0,1'h0,2'h2,6'h11},
        '{3'h2,1'h0,1'h0,4'h0,6'h00,32'h22222222,1'h0,1'h0,2'h2,6'h10},
        '{3'h2,1'h0,1'h0,4'hf,6'h00,32'h33333333,1'h0,1'h0,2'h2,6'h13},
        '{3'h2,1'h0,1'h0,4'he,6'h00,32'h000000ab,1'h0,1'h0,2'h2,6'h12},
        '{3'h2,1'h0,1'h0,4'hf,6'h00,32'h44444444,1'h0,1'h0,2'h2,6'h11},
        '{3'h2,1'h1,1'h0,4'h0,6'h00,32'h55555555,1'h0,1'h0,2'h2,6'h11},
        '{3'h1,1'h0,1'h0,4'h7,6'h11,32'hdd000000,1'h0,1'h0,2'h2,6'h11},
        '{3'h0,1'h0,1'h0,4'hf,6'h11,32'hdd111111,1'h1,1'h1,2'h1,6'h11},
        '{3'h2,1'h0,1'h0,4'hf,6'h00,32'h22222222,1'h1,1'h1,2'h1,6'h10},
        '{3'h2,1'h1,1'h0,4'h0,6'h00,32'h22222222,1'h1,1'h1,2'h1,6'h10},
        '{3'h2,1'h0,1'h1,4'hf,6'h00,32'h0,1'h0,1'h0,2'h1,6'h13},
        '{3'h2,1'h0,1'h0,4'hf,6'h00,32'h0,1'h0,1'h1,2'h1,6'h12},
        '{3'h3,1'h0,1'h0,4'hf,6'h11,32'h0,1'h0,1'h0,2'h0,6'h00},
        '{3'h2,1'h0,1'h0,4'hf,6'h00,32'h0,1'h0,1'h0,2'h0,6'h00},
        '{3'h4,1'h0,1'h0,4'hf,6'h11,32'h0,1'h0,1'h0,2'h0,6'h00},
        '{3'h0,1'h0,1'h1,4'hf,6'h10,32'h0,1'h0,1'h0,2'h1,6'h10},
        '{3'h5,1'h0,1'h0,4'hf,6'h10,32'h0,1'h0,1'h0,2'h0,6'h00},
        '{3'h1,1'h0,1'h0,4'hf,6'h10,32'h99999999,1'h0,1'h0,2'h2,6'h10},
        '{3'h0,1'h0,1'h0,4'hf,6'h10,32'h22222222,1'h1,1'h1,2'h1,6'h10},
        '{3'h1,1'h0,1'h0,4'h0,6'h13,32'h13131313,1'h0,1'h0,2'h2,6'h13},
        '{3'h2,1'h0,1'h0,4'h0,6'h00,32'h20202020,1'h0,1'h0,2'h2,6'h10},
        '{3'h2,1'h0,1'h0,4'hf,6'h00,32'h0,1'h0,1'h0,2'h2,6'h11},
        '{3'h2,1'h0,1'h0,4'hf,6'h00,32'h0,1'h0,1'h0,2'h2,6'h12},
        '{3'h2,1'h0,1'h0,4'hf,6'h00,32'h0,1'h0,1'h0,2'h2,6'h13},
        '{3'h0,1'h0,1'h0,4'hf,6'h13,32'h13131313,1'h1,1'h1,2'h1,6'h13}};
    logic             sys_clk;
    logic             nrst_n;
    logic             order;
    fbs_row_t         cur;
    fbs_row_t         pend;
    logic             cur_en;
    logic             pend_en;
    int               error_cnt;
    int               tests_run;
    int               cycles;
    wire logic        first_n;
    wire logic        second;
    wire logic        third_n;
    wire logic        adv;
    wire logic        rnw;
    wire logic        hold;
    wire logic [3:0]  lanes_n;
    wire logic [5:0]  addr;
    wire logic [31:0] wdata;
    wire logic [31:0] rdata;
    wire logic        dq_oe;
    wire logic        wbuf_ready;
    wire logic [1:0]  state;
    wire logic [5:0]  baddr;

    fbs_host_model #(.ADDR_W(6)) fbs_host_model_inst (
        .op_i(cur.op), .hold_i(cur.hold), .lanes_n_i(cur.lanes_n), .addr_i(cur.addr),
        .data_i(cur.data), .first_n_o(first_n), .second_o(second), .third_n_o(third_n),
        .adv_o(adv), .rnw_o(rnw), .hold_o(hold), .lanes_n_o(lanes_n), .addr_o(addr),
        .data_o(wdata));
    fbs_ctrl #(.ADDR_W(6), .WBUF_DEPTH(fbs_pkg::WBUF_DEPTH)) fbs_ctrl_inst (
        .SYS_CLK_I(sys_clk), .NRST_I(nrst_n), .CHIP_SELECT_FIRST_N_I(first_n),
        .CHIP_SELECT_SECOND_I(second), .CHIP_SELECT_THIRD_N_I(third_n),
        .ADVANCE_OR_LOAD_I(adv), .READ_NOT_WRITE_I(rnw), .CLOCK_HOLD_N_I(hold),
        .LANE_A_WRITE_N_I(lanes_n[0]), .LANE_B_WRITE_N_I(lanes_n[1]),
        .LANE_C_WRITE_N_I(lanes_n[2]), .LANE_D_WRITE_N_I(lanes_n[3]),
        .BURST_ORDER_SELECT_I(order), .OUTPUT_ENABLE_N_I(pend.oe_n), .ADDR_I(addr),
        .DQ_I(wdata), .DQ_O(rdata), .DQ_OE_O(dq_oe), .WBUF_READY_O(wbuf_ready),
        .BURST_STATE_O(state), .BURST_ADDR_O(baddr));

    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Order select is only changed under reset, as the block expects it to be static.
    task automatic do_reset(input logic ord);
        @(posedge sys_clk);
        nrst_n <= 1'b0;
        order  <= ord;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        check_val("reset drive", 32'h0, {31'h0, dq_oe});
        check_val("reset state", 32'h0, {24'h0, state, baddr});
        check_val("reset buffer ready", 32'h1, {31'h0, wbuf_ready});
        @(posedge sys_clk);
        nrst_n <= 1'b1;
        // The order select needs two edges after release to pass its synchroniser.
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic run_rows(input int first, input int last);
        for (int i = first; i <= last; i++)
        begin
            cur    <= ROWS[i];
            cur_en <= 1'b1;
            @(posedge sys_clk);
        end
        cur    <= IDLE;
        cur_en <= 1'b0;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Each row's answer is judged mid-cycle after the edge that took it.
    always @(posedge sys_clk)
    begin
        pend    <= cur;
        pend_en <= cur_en;
        cycles  <= cycles + 1;
        if (cycles == 400)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    always @(negedge sys_clk)
    begin
        if (pend_en === 1'b1)
        begin
            check_val("drive enable", {31'h0, pend.exp_oe}, {31'h0, dq_oe});
            check_val("burst state", {30'h0, pend.exp_st}, {30'h0, state});
            if (pend.exp_st != 2'h0)
                check_val("burst address", {26'h0, pend.exp_ba}, {26'h0, baddr});
            if (pend.chk_dq)
                check_val("read data", pend.data, rdata);
        end
    end

    initial
    begin
        nrst_n    = 1'b0;
        order     = 1'b1;
        cur       = IDLE;
        pend      = IDLE;
        cur_en    = 1'b0;
        pend_en   = 1'b0;
        error_cnt = 0;
        tests_run = 0;
        cycles    = 0;
        do_reset(1'b1);
        run_rows(0, 18);
        do_reset(1'b0);
        run_rows(19, 24);
        @(posedge sys_clk);
        @(posedge sys_clk);
        print_verdict();
    end
endmodule
`default_nettype wire
